// File: rtl/ccd_pkg.sv
// Package with register offsets, reset values, field positions and state codes for the channel clock divider.
package ccd_pkg;

  // Register offsets as printed on the serial register map.
  localparam logic [9:0] DIV0_CYCLE_COUNTS_OFS      = 10'h190;
  localparam logic [9:0] DIV0_CONTROL_OFS           = 10'h191;
  localparam logic [9:0] CHAN0_POWER_CORRECTION_OFS = 10'h192;
  localparam logic [9:0] DIV1_CYCLE_COUNTS_OFS      = 10'h193;
  localparam logic [9:0] DIV1_CONTROL_OFS           = 10'h194;

  // Values after reset.
  localparam logic [7:0] DIV0_CYCLE_COUNTS_RST      = 8'h77;
  localparam logic [7:0] DIV1_CYCLE_COUNTS_RST      = 8'h33;
  localparam logic [7:0] DIV_CONTROL_RST            = 8'h00;
  localparam logic [7:0] CHAN_POWER_CORRECTION_RST  = 8'h00;

  // Field positions inside the cycle count, control and power and correction registers.
  localparam int LOW_COUNT_MSB   = 7;
  localparam int LOW_COUNT_LSB   = 4;
  localparam int HIGH_COUNT_MSB  = 3;
  localparam int HIGH_COUNT_LSB  = 0;
  localparam int BYPASS_BIT      = 7;
  localparam int IGNORE_SYNC_BIT = 6;
  localparam int FORCE_HIGH_BIT  = 5;
  localparam int START_HIGH_BIT  = 4;
  localparam int PHASE_MSB       = 3;
  localparam int PHASE_LSB       = 0;
  localparam int POWER_DOWN_BIT  = 2;
  localparam int DCC_DISABLE_BIT = 0;

  // Writable bits of the power and correction register; the rest read as zero.
  localparam logic [7:0] CHAN_POWER_CORRECTION_MASK = 8'h05;

  // Divider sequencing states, one-hot.
  typedef enum logic [2:0] {
    CCD_ST_HOLD  = 3'b001,
    CCD_ST_DELAY = 3'b010,
    CCD_ST_RUN   = 3'b100
  } ccd_state_t;

endpackage : ccd_pkg

// File: rtl/ccd_divider.sv
// One channel divider: high and low counts, start level, phase delay, correction, force and bypass.
`timescale 1ns/1ps
module ccd_divider (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic [3:0] i_low_count,
  input  wire logic [3:0] i_high_count,
  input  wire logic [3:0] i_phase,
  input  wire logic       i_start_high,
  input  wire logic       i_dcc_en,
  input  wire logic       i_sync_hold,
  input  wire logic       i_force_en,
  input  wire logic       i_force_level,
  input  wire logic       i_bypass,
  output logic            o_clk_out
);

  ccd_pkg::ccd_state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic       level_q, level_d;
  logic [5:0] total;
  logic [5:0] hi_len;
  logic [5:0] lo_len;
  logic [5:0] cur_len;

  // Phase lengths; correction splits the whole period evenly, odd periods get the extra cycle low.
  always_comb begin
    total = 6'({2'b00, i_low_count} + {2'b00, i_high_count} + 6'h02);
    if (i_dcc_en) begin
      hi_len = {1'b0, total[5:1]};
      lo_len = 6'(total - {1'b0, total[5:1]});
    end else begin
      hi_len = 6'({2'b00, i_high_count} + 6'h01);
      lo_len = 6'({2'b00, i_low_count} + 6'h01);
    end
    cur_len = level_q ? hi_len : lo_len;
  end

  // Next state: bypass and an obeyed sync park the divider at its start level.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    level_d = level_q;
    if (i_bypass || i_sync_hold) begin
      state_d = ccd_pkg::CCD_ST_HOLD;
      cnt_d   = 6'h00;
      level_d = i_start_high;
    end else begin
      case (state_q)
        ccd_pkg::CCD_ST_HOLD: begin
          level_d = i_start_high;
          cnt_d   = 6'h00;
          if (i_phase == 4'h0) begin
            state_d = ccd_pkg::CCD_ST_RUN;
          end else begin
            state_d = ccd_pkg::CCD_ST_DELAY;
            cnt_d   = {2'b00, i_phase};
          end
        end
        ccd_pkg::CCD_ST_DELAY: begin
          if (cnt_q <= 6'h01) begin
            state_d = ccd_pkg::CCD_ST_RUN;
            cnt_d   = 6'h00;
          end else begin
            cnt_d = 6'(cnt_q - 6'h01);
          end
        end
        ccd_pkg::CCD_ST_RUN: begin
          if (cnt_q >= 6'(cur_len - 6'h01)) begin
            level_d = ~level_q;
            cnt_d   = 6'h00;
          end else begin
            cnt_d = 6'(cnt_q + 6'h01);
          end
        end
        default: begin
          state_d = ccd_pkg::CCD_ST_HOLD;
          cnt_d   = 6'h00;
        end
      endcase
    end
  end

  // State registers.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ccd_pkg::CCD_ST_HOLD;
      cnt_q   <= 6'h00;
      level_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  // Bypass hands the input clock straight out, so the force bit cannot reach the pin then.
  assign o_clk_out = i_bypass ? i_clock : (i_force_en ? i_force_level : level_q);

  a_low_length: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_q == ccd_pkg::CCD_ST_RUN && !level_q && !i_dcc_en && !i_bypass && !i_sync_hold &&
     cnt_q == {2'b00, i_low_count}) |=> level_q)
    else $error("Low phase did not end after low count plus one cycles.");

  a_high_length: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_q == ccd_pkg::CCD_ST_RUN && level_q && !i_dcc_en && !i_bypass && !i_sync_hold &&
     cnt_q < {2'b00, i_high_count} && $stable(i_high_count)) |=> level_q)
    else $error("High phase ended before high count plus one cycles.");

  a_bypass_parks: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_bypass |=> state_q == ccd_pkg::CCD_ST_HOLD)
    else $error("Divider kept running while bypassed.");

  a_sync_obeyed: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_sync_hold |=> (state_q == ccd_pkg::CCD_ST_HOLD && level_q == $past(i_start_high)))
    else $error("Divider did not hold during an obeyed sync.");

  a_start_level: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_q == ccd_pkg::CCD_ST_RUN && $past(state_q) != ccd_pkg::CCD_ST_RUN) |-> level_q == $past(i_start_high))
    else $error("Division did not begin at the selected start level.");

  a_phase_delay: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (state_q == ccd_pkg::CCD_ST_HOLD && !i_bypass && !i_sync_hold && i_phase != 4'h0)
    |=> (state_q == ccd_pkg::CCD_ST_DELAY && cnt_q == {2'b00, $past(i_phase)}))
    else $error("Phase offset delay was not loaded.");

  a_dcc_balance: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    i_dcc_en |-> (6'(hi_len + lo_len) == total && 6'(lo_len - hi_len) <= 6'h01))
    else $error("Corrected phases do not split the period evenly.");

endmodule : ccd_divider

// File: rtl/ccd_channel_clock_divider.sv
// Top of the channel clock divider: register file, sync input, two dividers and the channel 0 output group.
`timescale 1ns/1ps
module ccd_channel_clock_divider (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic [9:0] i_reg_addr,
  input  wire logic       i_reg_write,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_sync_n,
  output logic            o_group0_first_output,
  output logic            o_group0_first_output_oe,
  output logic            o_group0_second_output,
  output logic            o_group0_second_output_oe,
  output logic            o_group0_third_output,
  output logic            o_group0_third_output_oe,
  output logic            o_div1_output
);

  logic [7:0] div0_cycle_counts_q, div0_cycle_counts_d;
  logic [7:0] div0_control_q, div0_control_d;
  logic [7:0] chan0_power_correction_q, chan0_power_correction_d;
  logic [7:0] div1_cycle_counts_q, div1_cycle_counts_d;
  logic [7:0] div1_control_q, div1_control_d;
  logic [7:0] rdata_q, rdata_d;
  logic       sync_meta_q;
  logic       sync_n_q;
  logic       sync_active;
  logic       ignore0;
  logic       ignore1;
  logic       bypass0;
  logic       bypass1;
  logic       power_down0;
  logic       div0_clk;
  logic       div1_clk;

  // Register writes; only the documented bits of the power and correction register are kept.
  // The port never stalls, so a write takes effect at the edge that samples the strobe.
  always_comb begin
    div0_cycle_counts_d      = div0_cycle_counts_q;
    div0_control_d           = div0_control_q;
    chan0_power_correction_d = chan0_power_correction_q;
    div1_cycle_counts_d      = div1_cycle_counts_q;
    div1_control_d           = div1_control_q;
    if (i_reg_write) begin
      case (i_reg_addr)
        ccd_pkg::DIV0_CYCLE_COUNTS_OFS:      div0_cycle_counts_d = i_reg_wdata;
        ccd_pkg::DIV0_CONTROL_OFS:           div0_control_d = i_reg_wdata;
        ccd_pkg::CHAN0_POWER_CORRECTION_OFS: chan0_power_correction_d = i_reg_wdata & ccd_pkg::CHAN_POWER_CORRECTION_MASK;
        ccd_pkg::DIV1_CYCLE_COUNTS_OFS:      div1_cycle_counts_d = i_reg_wdata;
        ccd_pkg::DIV1_CONTROL_OFS:           div1_control_d = i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data is the addressed register one cycle later; unmapped addresses read zero.
  // Reading has no side effects, so software may poll any register freely.
  always_comb begin
    case (i_reg_addr)
      ccd_pkg::DIV0_CYCLE_COUNTS_OFS:      rdata_d = div0_cycle_counts_q;
      ccd_pkg::DIV0_CONTROL_OFS:           rdata_d = div0_control_q;
      ccd_pkg::CHAN0_POWER_CORRECTION_OFS: rdata_d = chan0_power_correction_q;
      ccd_pkg::DIV1_CYCLE_COUNTS_OFS:      rdata_d = div1_cycle_counts_q;
      ccd_pkg::DIV1_CONTROL_OFS:           rdata_d = div1_control_q;
      default:                             rdata_d = 8'h00;
    endcase
  end

  // Register file with its documented reset values.
  // Channel 1 resets to shorter counts than channel 0, so the two outputs differ from the first period.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div0_cycle_counts_q      <= ccd_pkg::DIV0_CYCLE_COUNTS_RST;
      div0_control_q           <= ccd_pkg::DIV_CONTROL_RST;
      chan0_power_correction_q <= ccd_pkg::CHAN_POWER_CORRECTION_RST;
      div1_cycle_counts_q      <= ccd_pkg::DIV1_CYCLE_COUNTS_RST;
      div1_control_q           <= ccd_pkg::DIV_CONTROL_RST;
      rdata_q                  <= 8'h00;
    end else begin
      div0_cycle_counts_q      <= div0_cycle_counts_d;
      div0_control_q           <= div0_control_d;
      chan0_power_correction_q <= chan0_power_correction_d;
      div1_cycle_counts_q      <= div1_cycle_counts_d;
      div1_control_q           <= div1_control_d;
      rdata_q                  <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  // The sync pin is asynchronous, so it passes two flip-flops before any divider sees it.
  // These two cycles of latency come before any phase offset count and apply to both channels alike.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_meta_q <= 1'b1;
      sync_n_q    <= 1'b1;
    end else begin
      sync_meta_q <= i_sync_n;
      sync_n_q    <= sync_meta_q;
    end
  end

  // Control decode per channel.
  // A divider that ignores sync shows its force level only while sync is asserted; otherwise it runs freely.
  always_comb begin
    sync_active = ~sync_n_q;
    ignore0     = div0_control_q[ccd_pkg::IGNORE_SYNC_BIT];
    ignore1     = div1_control_q[ccd_pkg::IGNORE_SYNC_BIT];
    bypass0     = div0_control_q[ccd_pkg::BYPASS_BIT];
    bypass1     = div1_control_q[ccd_pkg::BYPASS_BIT];
    power_down0 = chan0_power_correction_q[ccd_pkg::POWER_DOWN_BIT];
  end

  // Channel 0 divider; an ignoring divider is forced instead of held while sync is asserted.
  ccd_divider u_div0 (
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_low_count   (div0_cycle_counts_q[ccd_pkg::LOW_COUNT_MSB:ccd_pkg::LOW_COUNT_LSB]),
    .i_high_count  (div0_cycle_counts_q[ccd_pkg::HIGH_COUNT_MSB:ccd_pkg::HIGH_COUNT_LSB]),
    .i_phase       (div0_control_q[ccd_pkg::PHASE_MSB:ccd_pkg::PHASE_LSB]),
    .i_start_high  (div0_control_q[ccd_pkg::START_HIGH_BIT]),
    .i_dcc_en      (~chan0_power_correction_q[ccd_pkg::DCC_DISABLE_BIT]),
    .i_sync_hold   (sync_active & ~ignore0),
    .i_force_en    (sync_active & ignore0),
    .i_force_level (div0_control_q[ccd_pkg::FORCE_HIGH_BIT]),
    .i_bypass      (bypass0),
    .o_clk_out     (div0_clk)
  );

  // Channel 1 has no correction bit here, so its counts are followed exactly.
  // Its phase offset is not mapped either, so it starts on the edge after sync is released.
  ccd_divider u_div1 (
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_low_count   (div1_cycle_counts_q[ccd_pkg::LOW_COUNT_MSB:ccd_pkg::LOW_COUNT_LSB]),
    .i_high_count  (div1_cycle_counts_q[ccd_pkg::HIGH_COUNT_MSB:ccd_pkg::HIGH_COUNT_LSB]),
    .i_phase       (4'h0),
    .i_start_high  (div1_control_q[ccd_pkg::START_HIGH_BIT]),
    .i_dcc_en      (1'b0),
    .i_sync_hold   (sync_active & ~ignore1),
    .i_force_en    (sync_active & ignore1),
    .i_force_level (div1_control_q[ccd_pkg::FORCE_HIGH_BIT]),
    .i_bypass      (bypass1),
    .o_clk_out     (div1_clk)
  );

  // Power-down releases all three pins of the group and parks their data low.
  // Parking the data low as well keeps a receiver that ignores the enable from seeing a clock.
  always_comb begin
    o_group0_first_output     = power_down0 ? 1'b0 : div0_clk;
    o_group0_second_output    = power_down0 ? 1'b0 : div0_clk;
    o_group0_third_output     = power_down0 ? 1'b0 : div0_clk;
    o_group0_first_output_oe  = ~power_down0;
    o_group0_second_output_oe = ~power_down0;
    o_group0_third_output_oe  = ~power_down0;
    o_div1_output             = div1_clk;
  end

  a_reset_div0: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ($past(i_reset_n) == 1'b0 && !$past(i_reg_write)) |-> div0_cycle_counts_q == 8'h77)
    else $error("Divider 0 counts did not reset to seven and seven.");

  a_reset_div1: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ($past(i_reset_n) == 1'b0 && !$past(i_reg_write)) |-> div1_cycle_counts_q == 8'h33)
    else $error("Divider 1 counts did not reset to three and three.");

  a_phase_reset: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ($past(i_reset_n) == 1'b0 && !$past(i_reg_write)) |-> div0_control_q[3:0] == 4'h0)
    else $error("Phase offset did not reset to zero.");

  a_power_down: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    power_down0 |-> (!o_group0_first_output_oe && !o_group0_second_output_oe && !o_group0_third_output_oe))
    else $error("Powered-down group still drives its pins.");

  a_force_level: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (sync_active && ignore0 && !bypass0 && !power_down0)
    |-> o_group0_first_output == div0_control_q[ccd_pkg::FORCE_HIGH_BIT])
    else $error("Forced level not shown on the group output.");

  // Checks on the register file, the sync path and the output group.
  // The hold checks look one cycle after sync, because a divider parks on the edge after it sees sync.
  a_counts_write: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == ccd_pkg::DIV0_CYCLE_COUNTS_OFS) |=> div0_cycle_counts_q == $past(i_reg_wdata))
    else $error("Divider 0 count write did not land.");

  a_power_mask: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (i_reg_write && i_reg_addr == ccd_pkg::CHAN0_POWER_CORRECTION_OFS)
    |=> chan0_power_correction_q == ($past(i_reg_wdata) & 8'h05))
    else $error("Power and correction register kept undocumented bits.");

  a_group_equal: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !power_down0 |-> (o_group0_first_output_oe && o_group0_second_output_oe && o_group0_third_output_oe &&
     o_group0_second_output == o_group0_first_output && o_group0_third_output == o_group0_first_output))
    else $error("Group outputs differ or are released while powered up.");

  a_obey_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ($past(sync_active) && sync_active && !ignore0 && !bypass0 && !power_down0 && $stable(div0_control_q))
    |-> o_group0_first_output == div0_control_q[ccd_pkg::START_HIGH_BIT])
    else $error("Obeying divider 0 did not hold its start level during sync.");

  a_obey_hold_div1: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    ($past(sync_active) && sync_active && !ignore1 && !bypass1 && $stable(div1_control_q))
    |-> o_div1_output == div1_control_q[ccd_pkg::START_HIGH_BIT])
    else $error("Obeying divider 1 did not hold its start level during sync.");

  a_bypass_clock: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (bypass0 && !power_down0) |-> o_group0_first_output == i_clock)
    else $error("Bypassed group output does not follow the input clock.");

endmodule : ccd_channel_clock_divider

// File: tb/ccd_clock_sink.sv
// Downstream receiver model that measures the high and low run lengths of one divided clock.
`timescale 1ns/1ps
module ccd_clock_sink (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_enable,
  input  wire logic       i_clk_in,
  output logic            o_period_done,
  output logic      [5:0] o_high_len,
  output logic      [5:0] o_low_len
);
  logic       prev_q;
  logic [5:0] cnt_q;
  logic [1:0] seen_q;

  // Runs are counted in input clock cycles; partial runs after enable are dropped, so a period is reported only once
  // both of its halves began at an observed transition.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_q        <= 1'b0;
      cnt_q         <= 6'h01;
      seen_q        <= 2'h0;
      o_period_done <= 1'b0;
      o_high_len    <= 6'h00;
      o_low_len     <= 6'h00;
    end else begin
      o_period_done <= 1'b0;
      prev_q        <= i_clk_in;
      if (!i_enable) begin
        cnt_q  <= 6'h01;
        seen_q <= 2'h0;
      end else if (i_clk_in != prev_q) begin
        cnt_q <= 6'h01;
        if (seen_q != 2'h3) begin
          seen_q <= seen_q + 2'h1;
        end
        if (prev_q) begin
          o_high_len <= cnt_q;
        end else if (seen_q >= 2'h2) begin
          o_low_len     <= cnt_q;
          o_period_done <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
endmodule : ccd_clock_sink

// File: tb/tb_top.sv
// Self-checking bench for the channel clock divider: registers, division, sync, force, bypass and power-down.
`timescale 1ns/1ps
module tb_top;
  logic        i_clock;
  logic        i_reset_n;
  logic  [9:0] i_reg_addr;
  logic        i_reg_write;
  logic  [7:0] i_reg_wdata;
  logic  [7:0] o_reg_rdata;
  logic        i_sync_n;
  logic  [2:0] out;
  logic  [2:0] oe;
  logic        o_div1_output;
  logic        sink_en;
  logic        sink_sel;
  logic        sink_in;
  logic        done;
  logic  [5:0] high_len;
  logic  [5:0] low_len;
  logic [11:0] notes[$];
  logic [31:0] r;
  logic  [7:0] rst_val[6] = '{8'h77, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00};
  logic  [7:0] lvl_ctrl[4] = '{8'h60, 8'h40, 8'h00, 8'h10};
  logic        lvl_exp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int          fails;
  int          tests_run;
  int          seed;
  int          k;
  int          n0;
  int          n4;

  ccd_channel_clock_divider uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_write(i_reg_write), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_sync_n(i_sync_n),
    .o_group0_first_output(out[0]), .o_group0_first_output_oe(oe[0]), .o_group0_second_output(out[1]),
    .o_group0_second_output_oe(oe[1]), .o_group0_third_output(out[2]), .o_group0_third_output_oe(oe[2]),
    .o_div1_output(o_div1_output));

  // One receiver model, switched between the two divided clocks.
  assign sink_in = sink_sel ? o_div1_output : out[0];
  ccd_clock_sink sink (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_enable(sink_en), .i_clk_in(sink_in),
    .o_period_done(done), .o_high_len(high_len), .o_low_len(low_len));

  // Free-running 125 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_period(input logic [11:0] exp);
    tests_run++;
    if ({high_len, low_len} !== exp) begin
      fails++;
      $display("unexpected at %0t: period got %h expected %h", $time, {high_len, low_len}, exp);
    end
  endtask : check_period

  // The watcher pops the oldest expected period whenever the receiver reports one.
  always @(posedge i_clock) begin
    if (done === 1'b1 && notes.size() > 0) begin
      check_period(notes.pop_front());
    end
  end

  task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_write <= 1'b1;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask : reg_write

  // Read data is registered, so it is looked at one edge after the address was taken.
  task automatic reg_check(input logic [9:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_reg_addr <= a;
    repeat (2) @(posedge i_clock);
    #1 check_val(o_reg_rdata, exp, "register");
  endtask : reg_check

  // Writes under a held sync so the divider restarts cleanly from its start level.
  task automatic restart(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sync_n <= 1'b0;
    reg_write(a, d);
    repeat (4) @(posedge i_clock);
    i_sync_n <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask : restart

  task automatic measure(input logic sel, input logic [5:0] hi, input logic [5:0] lo, input int n, input string nm);
    int i;
    sink_sel <= sel;
    for (i = 0; i < n; i++) begin
      notes.push_back({hi, lo});
    end
    @(posedge i_clock);
    sink_en <= 1'b1;
    i = 0;
    while (notes.size() > 0 && i < 2000) begin
      @(posedge i_clock);
      i++;
    end
    check_val(8'(notes.size()), 8'h00, "periods missing");
    notes.delete();
    sink_en <= 1'b0;
    $display("test %s done", nm);
  endtask : measure

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Watchdog sized well above the full sequence.
  initial begin
    repeat (40000) @(posedge i_clock);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence.
  initial begin
    seed = 32'haa53;
    fails = 0;
    tests_run = 0;
    i_reset_n = 1'b0;
    i_reg_addr = 10'h000;
    i_reg_write = 1'b0;
    i_reg_wdata = 8'h00;
    i_sync_n = 1'b1;
    sink_en = 1'b0;
    sink_sel = 1'b0;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    measure(1'b1, 6'h04, 6'h04, 3, "divider 1 default");
    measure(1'b0, 6'h08, 6'h08, 2, "divider 0 default");
    for (int i = 0; i < 6; i++) begin
      reg_check(10'h190 + i[9:0], rst_val[i]);
    end
    reg_write(10'h192, 8'hff);
    reg_check(10'h192, 8'h05);
    reg_write(10'h3ff, 8'h5a);
    reg_check(10'h3ff, 8'h00);
    reg_write(10'h192, 8'h00);
    $display("test registers done");
    restart(10'h190, 8'h03);
    measure(1'b0, 6'h02, 6'h03, 2, "correction on");
    reg_write(10'h192, 8'h01);
    restart(10'h190, 8'h03);
    measure(1'b0, 6'h04, 6'h01, 2, "correction off");
    // Three random counts with correction off, each drawn from the full field range.
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      restart(10'h190, r[7:0]);
      measure(1'b0, {2'h0, r[3:0]} + 6'h01, {2'h0, r[7:4]} + 6'h01, 2, "random counts");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      i_sync_n <= 1'b0;
      reg_write(10'h191, lvl_ctrl[i]);
      reg_write(10'h194, lvl_ctrl[i]);
      repeat (4) @(posedge i_clock);
      for (int j = 0; j < 3; j++) begin
        repeat (3) @(posedge i_clock);
        #1 check_val({4'h0, o_div1_output, out}, {4'h0, {4{lvl_exp[i]}}}, "held level");
      end
    end
    $display("test static levels done");
    for (int i = 0; i < 2; i++) begin
      reg_write(10'h191, i ? 8'hc0 : 8'he0);
      reg_write(10'h194, i ? 8'hc0 : 8'he0);
      repeat (2) @(posedge i_clock);
      #1 check_val({4'h0, o_div1_output, out}, 8'h0f, "bypass high");
      @(negedge i_clock);
      #1 check_val({4'h0, o_div1_output, out}, 8'h00, "bypass low");
    end
    $display("test bypass done");
    for (int p = 0; p < 2; p++) begin
      reg_write(10'h191, p ? 8'h04 : 8'h00);
      repeat (4) @(posedge i_clock);
      i_sync_n <= 1'b1;
      k = 0;
      while (out[0] !== 1'b1 && k < 100) begin
        @(posedge i_clock);
        #1 k++;
      end
      if (p == 1) n4 = k;
      else n0 = k;
      @(posedge i_clock);
      i_sync_n <= 1'b0;
    end
    check_val(8'(n4 - n0), 8'h04, "phase delay");
    $display("test phase done");
    check_val({5'h00, oe}, 8'h07, "drivers enabled");
    reg_write(10'h192, 8'h05);
    @(posedge i_clock);
    #1 check_val({2'h0, oe, out}, 8'h00, "power-down");
    reg_write(10'h192, 8'h01);
    @(posedge i_clock);
    #1 check_val({5'h00, oe}, 8'h07, "power-up");
    $display("test power-down done");
    give_verdict();
  end
endmodule : tb_top
